//--- hdl/rail_order_pkg.sv
// constants for the converter rail ordering block
package rail_order_pkg;
  localparam logic [7:0] ORDER_ONE_TWO_ADDR = 8'h2c;
  localparam logic [7:0] ORDER_THREE_FOUR_ADDR = 8'h2d;
  localparam int CODE_W = 4;
  localparam int RAIL_COUNT = 4;
  localparam int LOW_FIELD_LSB = 0;
  localparam int HIGH_FIELD_LSB = 4;
  localparam logic [7:0] ORDER_RESET = 8'h00;
  localparam logic [3:0] CODE_OFF = 4'h0;
  localparam logic [3:0] SLOT_FIRST = 4'h1;
  localparam logic [3:0] SLOT_LAST = 4'hc;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_UP,
    SEQ_DOWN
  } seq_state_e;
endpackage

//--- hdl/rail_order_seq.sv
// order registers and slot sequencer for four converter rails
// Contract
// - code zero keeps rail out of sequence
// - power-up enables rails in ascending slots
// - power-down disables rails in reverse order
// - converter one code at 2c bits 3:0
// - converter two code at 2c bits 7:4
// - converter three code at 2d bits 3:0
// - converter four code at 2d bits 7:4
`timescale 1ns/1ps
module rail_order_seq (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] option_codes,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic power_up_req,
  input wire logic power_down_req,
  input wire logic slot_tick,
  output logic [rail_order_pkg::RAIL_COUNT-1:0] rail_en,
  output logic [3:0] current_slot,
  output logic seq_busy,
  output logic seq_done
);
  import rail_order_pkg::*;

  logic rst_meta;
  logic rst_sync_n;
  logic loaded;
  logic wr_hit;
  logic rd_hit;
  logic addr_idx;
  logic [15:0] words;
  logic [CODE_W-1:0] codes [RAIL_COUNT];
  logic [RAIL_COUNT-1:0] slot_match;
  seq_state_e state;
  seq_state_e next_state;
  logic [3:0] next_slot;
  logic [RAIL_COUNT-1:0] next_rail_en;
  logic next_busy;
  logic next_done;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // factory option codes are captured once, on the first enabled cycle after release
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      loaded <= 1'b0;
    end else if (ce) begin
      loaded <= 1'b1;
    end
  end

  assign addr_idx = (reg_addr == ORDER_THREE_FOUR_ADDR);
  assign rd_hit = (reg_addr == ORDER_ONE_TWO_ADDR) || addr_idx;
  assign wr_hit = reg_wr && rd_hit && loaded;

  rail_order_store store (
    .ref_clk(ref_clk),
    .rst_n(rst_sync_n),
    .ce(ce),
    .load_en(!loaded),
    .load_data(option_codes),
    .wr_en(wr_hit),
    .wr_idx(addr_idx),
    .wr_data(reg_wdata),
    .rd_en(reg_rd),
    .rd_hit(rd_hit),
    .rd_idx(addr_idx),
    .rd_data(reg_rdata),
    .words(words)
  );

  assign codes[0] = words[LOW_FIELD_LSB +: CODE_W];
  assign codes[1] = words[HIGH_FIELD_LSB +: CODE_W];
  assign codes[2] = words[8 + LOW_FIELD_LSB +: CODE_W];
  assign codes[3] = words[8 + HIGH_FIELD_LSB +: CODE_W];

  genvar g;
  generate
    for (g = 0; g < RAIL_COUNT; g++) begin : g_match
      // rails sharing a code switch together; zero never matches a slot
      assign slot_match[g] = (codes[g] != CODE_OFF) && (codes[g] == current_slot);
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_slot = current_slot;
    next_rail_en = rail_en;
    next_busy = seq_busy;
    next_done = 1'b0;
    case (state)
      SEQ_IDLE: begin
        if (power_up_req) begin
          next_state = SEQ_UP;
          next_slot = SLOT_FIRST;
          next_busy = 1'b1;
        end else if (power_down_req) begin
          next_state = SEQ_DOWN;
          next_slot = SLOT_LAST;
          next_busy = 1'b1;
        end
      end
      SEQ_UP: begin
        if (slot_tick) begin
          next_rail_en = rail_en | slot_match;
          if (current_slot == SLOT_LAST) begin
            next_state = SEQ_IDLE;
            next_slot = CODE_OFF;
            next_busy = 1'b0;
            next_done = 1'b1;
          end else begin
            next_slot = current_slot + 4'h1;
          end
        end
      end
      SEQ_DOWN: begin
        if (slot_tick) begin
          next_rail_en = rail_en & ~slot_match;
          if (current_slot == SLOT_FIRST) begin
            // codes above the last slot were never sequenced, so drop any leftover
            next_rail_en = '0;
            next_state = SEQ_IDLE;
            next_slot = CODE_OFF;
            next_busy = 1'b0;
            next_done = 1'b1;
          end else begin
            next_slot = current_slot - 4'h1;
          end
        end
      end
      default: begin
        next_state = SEQ_IDLE;
        next_slot = CODE_OFF;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= SEQ_IDLE;
      current_slot <= CODE_OFF;
      rail_en <= '0;
      seq_busy <= 1'b0;
      seq_done <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      current_slot <= next_slot;
      rail_en <= next_rail_en;
      seq_busy <= next_busy;
      seq_done <= next_done;
    end
  end
endmodule

//--- hdl/rail_order_store.sv
// two-word storage for the rail order codes with registered read data
`timescale 1ns/1ps
module rail_order_store (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load_en,
  input wire logic [15:0] load_data,
  input wire logic wr_en,
  input wire logic wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_hit,
  input wire logic rd_idx,
  output logic [7:0] rd_data,
  output logic [15:0] words
);
  import rail_order_pkg::*;

  logic [7:0] mem [2];
  logic [7:0] next_mem [2];
  logic [7:0] next_rd_data;

  always_comb begin
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_rd_data = rd_data;
    if (load_en) begin
      next_mem[0] = load_data[7:0];
      next_mem[1] = load_data[15:8];
    end else if (wr_en) begin
      next_mem[wr_idx] = wr_data;
    end
    if (rd_en) begin
      next_rd_data = rd_hit ? mem[rd_idx] : UNMAPPED_READ;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem[0] <= ORDER_RESET;
      mem[1] <= ORDER_RESET;
      rd_data <= UNMAPPED_READ;
    end else if (ce) begin
      mem[0] <= next_mem[0];
      mem[1] <= next_mem[1];
      rd_data <= next_rd_data;
    end
  end

  assign words = {mem[1], mem[0]};
endmodule

//--- test/rail_order_seq_properties.sv
// assertions on the rail order block ports
`timescale 1ns/1ps
module rail_order_seq_checker (
  input wire logic ref_clk, rst_n, ce, reg_wr, reg_rd, power_up_req, power_down_req, slot_tick,
  input wire logic seq_busy, seq_done,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  input wire logic [3:0] rail_en, current_slot
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic dn;
  wire go = ce && !seq_busy;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) dn <= 1'b0;
    else if (go) dn <= power_down_req && !power_up_req;
  end
  chk_wr_rd_low: assert property (
    ce && reg_wr && reg_addr == 8'h2c ##1 ce && reg_rd && !reg_wr && reg_addr == 8'h2c
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("2c readback");
  chk_wr_rd_high: assert property (
    ce && reg_wr && reg_addr == 8'h2d ##1 ce && reg_rd && !reg_wr && reg_addr == 8'h2d
    |=> reg_rdata == $past(reg_wdata, 2)) else $error("2d readback");
  chk_unmapped_zero: assert property (ce && reg_rd && reg_addr[7:1] != 7'h16 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  chk_up_start: assert property (go && power_up_req |=> seq_busy && current_slot == 4'h1)
    else $error("up start");
  chk_down_start: assert property (go && power_down_req && !power_up_req |=> current_slot == 4'hc)
    else $error("down start");
  chk_slot_range: assert property (seq_busy |-> current_slot inside {[4'h1:4'hc]})
    else $error("slot range");
  chk_up_adds_only: assert property (seq_busy && !dn |=> ($past(rail_en) & ~rail_en) == 4'h0)
    else $error("rail dropped in up");
  chk_down_end: assert property (
    seq_busy && dn && ce && slot_tick && current_slot == 4'h1 |=> rail_en == 4'h0 && seq_done)
    else $error("down end");
  cover property (go && power_up_req);
  cover property (dn && seq_done);
  cover property (ce && reg_rd && reg_addr == 8'h2e);
endmodule
bind rail_order_seq rail_order_seq_checker chk_i (.*);

//--- test/tb_rail_order_seq.sv
// self-checking bench for the rail order block
`timescale 1ns/1ps
module tb_rail_order_seq;
  logic ref_clk = 0, rst_n = 0, ce = 1, reg_wr = 0, reg_rd = 0, slot_tick = 0;
  logic power_up_req = 0, power_down_req = 0, seq_busy, seq_done;
  logic [15:0] option_codes = 16'hc101, cw = 16'hc101;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] rail_en, current_slot, exp = 4'h0;
  int err_total = 0, checks = 0;
  logic [23:0] rows [6] = '{24'h2ca5a5, 24'h2d5a5a, 24'h2eff00, 24'h2b1100, 24'h2c0101, 24'h2dc1c1};
  rail_order_seq dut (.*);
  always #12.5 ref_clk = ~ref_clk;
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task wr_rd(input logic [7:0] a, d, input logic w, input logic [7:0] e);
    @(posedge ref_clk) #2 reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    @(posedge ref_clk) #2 reg_wr = 0;
    reg_rd = 1;
    @(posedge ref_clk) #2 reg_rd = 0;
    chk("rdata", reg_rdata, e);
  endtask
  // one full sequence, one tick per cycle, rails predicted from cw
  task go(input logic up);
    logic [3:0] s;
    @(posedge ref_clk) #2 power_up_req = up;
    power_down_req = !up;
    @(posedge ref_clk) #2 power_up_req = 0;
    power_down_req = 0;
    slot_tick = 1;
    chk("slot", current_slot, up ? 8'h1 : 8'hc);
    for (int i = 1; i <= 12; i++) begin
      s = up ? i[3:0] : 4'(13 - i);
      for (int r = 0; r < 4; r++) if (cw[4*r+:4] == s) exp[r] = up;
      if (!up && s == 4'h1) exp = 4'h0;
      @(posedge ref_clk) #2 chk("rails", rail_en, exp);
      if (i == 12) slot_tick = 0;
    end
    chk("done", {seq_done, seq_busy}, 8'h2);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    #2 rst_n = 1;
    chk("rails", rail_en, 8'h0);
    repeat (4) @(posedge ref_clk);
    wr_rd(8'h2c, 8'h00, 0, 8'h01);
    wr_rd(8'h2d, 8'h00, 0, 8'hc1);
    foreach (rows[i]) wr_rd(rows[i][23:16], rows[i][15:8], 1, rows[i][7:0]);
    go(1);
    go(0);
    wr_rd(8'h2d, 8'hd1, 1, 8'hd1);
    cw = 16'hd101;
    go(1);
    go(0);
    // awkward cases: request while busy, frozen clock enable, reset mid-sequence
    @(posedge ref_clk) #2 power_up_req = 1;
    @(posedge ref_clk) #2 power_up_req = 0;
    power_down_req = 1;
    slot_tick = 1;
    @(posedge ref_clk) #2 power_down_req = 0;
    chk("busy slot", {seq_busy, current_slot}, 8'h12);
    chk("rails", rail_en, 8'h5);
    ce = 0;
    repeat (3) @(posedge ref_clk);
    #2 chk("frozen", {rail_en, current_slot}, 8'h52);
    ce = 1;
    rst_n = 0;
    #1 chk("reset", {rail_en, current_slot}, 8'h00);
    slot_tick = 0;
    repeat (2) @(posedge ref_clk);
    #2 rst_n = 1;
    repeat (4) @(posedge ref_clk);
    wr_rd(8'h2d, 8'h00, 0, 8'hc1);
    end_of_test;
  end
endmodule
